// File: async_serial_port_one.v
// Asynchronous serial transmitter and receiver with Avalon-MM register slave
`timescale 1ns/100ps
`include "serial_port_consts.vh"

module async_serial_port_one (
   input wire i_clk,
   input wire i_rst,
   input wire [13:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [3:0] i_avs_byteenable,
   input wire [31:0] i_avs_writedata,
   output reg [31:0] o_avs_readdata,
   output reg o_avs_waitrequest,
   input wire i_timer_match,
   input wire i_serial_in_pin,
   output reg o_serial_out_pin,
   output reg o_tx_interrupt_port,
   output reg o_rx_interrupt_port
);

   localparam RX_IDLE = 5'b00001;
   localparam RX_START = 5'b00010;
   localparam RX_DATA = 5'b00100;
   localparam RX_PAR = 5'b01000;
   localparam RX_STOP = 5'b10000;

   // Main clock divisor of the sub-bit tick for a baud code
   function [8:0] baud_div;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: baud_div = `DIV_000;
            3'h1: baud_div = `DIV_001;
            3'h2: baud_div = `DIV_010;
            3'h3: baud_div = `DIV_011;
            3'h4: baud_div = `DIV_100;
            3'h5: baud_div = `DIV_101;
            default: baud_div = `DIV_111;
         endcase
      end
   endfunction

   // Persistence count of the input filter
   function [6:0] filt_len;
      input [1:0] sel;
      begin
         case (sel)
            2'h1: filt_len = `FILT_01;
            2'h2: filt_len = `FILT_10;
            default: filt_len = `FILT_11;
         endcase
      end
   endfunction

   reg [7:0] ctrl_one;
   reg [2:0] ctrl_two;
   reg parity_error_flag;
   reg framing_error_flag;
   reg overrun_flag;
   reg rx_buffer_full_flag;
   reg tx_done_flag;
   reg tx_buffer_empty_flag;
   reg [7:0] rx_hold;
   reg [7:0] tx_hold;
   reg tx_pending;
   reg arm_rx;
   reg arm_tx;
   reg [8:0] div_cnt;
   reg rt_tick;
   reg line;
   reg [6:0] filt_cnt;
   reg [4:0] rx_state;
   reg [3:0] rx_rt;
   reg [2:0] rx_samp;
   reg [2:0] rx_bit;
   reg [7:0] rx_shift;
   reg rx_second;
   reg rx_par_bad;
   reg rx_stop_bad;
   reg tx_busy;
   reg [3:0] tx_rt;
   reg [3:0] tx_left;
   reg [10:0] tx_shift;

   wire [2:0] baud_select = ctrl_one[`C1_BAUD_HI:`C1_BAUD_LO];
   wire [1:0] rx_noise_filter_sel = ctrl_two[`C2_FILT_HI:`C2_FILT_LO];
   wire rx_stop_len = ctrl_two[`C2_RX_STOP];
   wire tx_stop_len = ctrl_one[`C1_TX_STOP];
   wire parity_enable = ctrl_one[`C1_PAR_EN];
   wire even_parity = ctrl_one[`C1_EVEN];
   wire [11:0] word_idx = i_avs_address[13:2];
   wire bus_go = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
   wire wr_go = bus_go & i_avs_write & i_avs_byteenable[0];
   wire rd_go = bus_go & i_avs_read;
   wire sr_read = rd_go & (word_idx == `IDX_STATUS_CTRL1);
   wire rb_read = rd_go & (word_idx == `IDX_DATA);
   wire tb_write = wr_go & (word_idx == `IDX_DATA);
   wire tx_valid_write = tb_write & arm_tx & ctrl_one[`C1_TX_EN];
   wire vote = (rx_samp[0] & rx_samp[1]) | (rx_samp[0] & rx_samp[2]) |
      (rx_samp[1] & rx_samp[2]);
   wire rx_bit_end = rt_tick & (rx_rt == `TICKS_LAST);
   wire rx_frame_end = rx_bit_end & rx_state[4] & (rx_second | ~rx_stop_len);
   wire rx_deliver = rx_frame_end & ~rx_buffer_full_flag;
   wire tx_start = ~tx_busy & tx_pending & ctrl_one[`C1_TX_EN];
   wire tx_finish = tx_busy & rt_tick & (tx_rt == `TICKS_LAST) & (tx_left == 4'h1);
   wire [7:0] status = {parity_error_flag, framing_error_flag, overrun_flag, rx_buffer_full_flag, tx_done_flag, tx_buffer_empty_flag, 2'b00};

   // One wait cycle per access; read data registered with the wait release
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end else begin
         o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
         if (i_avs_read & o_avs_waitrequest) begin
            case (word_idx)
               `IDX_STATUS_CTRL1: o_avs_readdata <= {24'h000000, status};
               `IDX_DATA: o_avs_readdata <= {24'h000000, rx_hold};
               default: o_avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Write-only control registers
   always @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_one <= `C1_RESET;
         ctrl_two <= `C2_RESET;
      end else if (wr_go) begin
         if (word_idx == `IDX_STATUS_CTRL1)
            ctrl_one <= i_avs_writedata[7:0];
         if (word_idx == `IDX_CTRL2)
            ctrl_two <= i_avs_writedata[2:0];
      end
   end

   // Status-read arming for the buffer accesses that follow
   always @(posedge i_clk) begin
      if (i_rst) begin
         arm_rx <= 1'b0;
         arm_tx <= 1'b0;
      end else begin
         if (sr_read)
            arm_rx <= 1'b1;
         else if (rb_read)
            arm_rx <= 1'b0;
         if (sr_read)
            arm_tx <= 1'b1;
         else if (tb_write)
            arm_tx <= 1'b0;
      end
   end

   // Sub-bit tick from main clock divider or timer match
   always @(posedge i_clk) begin
      if (i_rst) begin
         div_cnt <= 9'd0;
         rt_tick <= 1'b0;
      end else if (baud_select == `BAUD_TIMER) begin
         div_cnt <= 9'd0;
         rt_tick <= i_timer_match;
      end else if (div_cnt >= baud_div(baud_select) - 9'd1) begin
         div_cnt <= 9'd0;
         rt_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 9'd1;
         rt_tick <= 1'b0;
      end
   end

   // Input noise filter: a new level must persist before it passes
   always @(posedge i_clk) begin
      if (i_rst) begin
         line <= 1'b1;
         filt_cnt <= 7'd0;
      end else if (rx_noise_filter_sel == 2'h0) begin
         line <= i_serial_in_pin;
         filt_cnt <= 7'd0;
      end else if (i_serial_in_pin == line) begin
         filt_cnt <= 7'd0;
      end else if (filt_cnt >= filt_len(rx_noise_filter_sel) - 7'd1) begin
         line <= i_serial_in_pin;
         filt_cnt <= 7'd0;
      end else begin
         filt_cnt <= filt_cnt + 7'd1;
      end
   end

   // Receive frame sequencer
   always @(posedge i_clk) begin
      if (i_rst) begin
         rx_state <= RX_IDLE;
         rx_rt <= 4'h0;
         rx_samp <= 3'h0;
         rx_bit <= 3'h0;
         rx_shift <= 8'h00;
         rx_second <= 1'b0;
         rx_par_bad <= 1'b0;
         rx_stop_bad <= 1'b0;
      end else if (rt_tick) begin
         rx_rt <= rx_rt + 4'h1;
         if (rx_rt == `SAMPLE_A || rx_rt == `SAMPLE_B || rx_rt == `SAMPLE_C)
            rx_samp <= {rx_samp[1:0], line};
         case (rx_state)
            RX_IDLE: begin
               rx_rt <= 4'h1;
               rx_second <= 1'b0;
               rx_par_bad <= 1'b0;
               rx_stop_bad <= 1'b0;
               // Enable and overrun only checked between frames
               if (~line & ctrl_one[`C1_RX_EN] & ~overrun_flag)
                  rx_state <= RX_START;
            end
            RX_START: begin
               if (rx_rt == `TICKS_LAST) begin
                  rx_bit <= 3'h0;
                  rx_state <= vote ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_rt == `TICKS_LAST) begin
                  rx_shift <= {vote, rx_shift[7:1]};
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == 3'h7)
                     rx_state <= parity_enable ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: begin
               if (rx_rt == `TICKS_LAST) begin
                  rx_par_bad <= (^rx_shift ^ ~even_parity) != vote;
                  rx_state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_rt == `TICKS_LAST) begin
                  rx_second <= 1'b1;
                  if (~vote)
                     rx_stop_bad <= 1'b1;
                  if (rx_second | ~rx_stop_len)
                     rx_state <= RX_IDLE;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // Receive buffer and flags; a set wins over the read clear
   always @(posedge i_clk) begin
      if (i_rst) begin
         rx_hold <= 8'h00;
         rx_buffer_full_flag <= 1'b0;
         overrun_flag <= 1'b0;
         parity_error_flag <= 1'b0;
         framing_error_flag <= 1'b0;
         o_rx_interrupt_port <= 1'b0;
      end else begin
         o_rx_interrupt_port <= rx_deliver;
         if (rb_read & arm_rx) begin
            rx_buffer_full_flag <= 1'b0;
            overrun_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            framing_error_flag <= 1'b0;
         end
         if (rx_deliver) begin
            rx_hold <= rx_shift;
            rx_buffer_full_flag <= 1'b1;
         end
         if (rx_frame_end & rx_buffer_full_flag)
            overrun_flag <= 1'b1;
         if (rx_frame_end & (rx_stop_bad | ~vote))
            framing_error_flag <= 1'b1;
         if (rx_frame_end & rx_par_bad & parity_enable)
            parity_error_flag <= 1'b1;
      end
   end

   // Transmit buffer and its flags
   always @(posedge i_clk) begin
      if (i_rst) begin
         tx_hold <= 8'h00;
         tx_pending <= 1'b0;
         tx_buffer_empty_flag <= 1'b1;
         tx_done_flag <= 1'b1;
         o_tx_interrupt_port <= 1'b0;
      end else begin
         o_tx_interrupt_port <= tx_start;
         if (tx_valid_write) begin
            tx_hold <= i_avs_writedata[7:0];
            tx_pending <= 1'b1;
            tx_buffer_empty_flag <= 1'b0;
         end
         if (tx_start) begin
            tx_pending <= 1'b0;
            tx_buffer_empty_flag <= 1'b1;
            tx_done_flag <= 1'b0;
         end
         if (tx_finish & ~tx_pending & ~tx_valid_write)
            tx_done_flag <= 1'b1;
      end
   end

   // Transmit shifter: start, data LSB first, parity, stops
   always @(posedge i_clk) begin
      if (i_rst) begin
         tx_busy <= 1'b0;
         tx_rt <= 4'h0;
         tx_left <= 4'h0;
         tx_shift <= 11'h7FF;
         o_serial_out_pin <= 1'b1;
      end else if (tx_start) begin
         tx_busy <= 1'b1;
         tx_rt <= 4'h0;
         tx_left <= 4'd10 + {3'h0, parity_enable} + {3'h0, tx_stop_len};
         if (parity_enable)
            tx_shift <= {1'b1, ^tx_hold ^ ~even_parity, tx_hold, 1'b0};
         else
            tx_shift <= {2'b11, tx_hold, 1'b0};
         o_serial_out_pin <= 1'b0;
      end else if (tx_busy) begin
         if (rt_tick) begin
            tx_rt <= tx_rt + 4'h1;
            if (tx_rt == `TICKS_LAST) begin
               tx_left <= tx_left - 4'h1;
               tx_shift <= {1'b1, tx_shift[10:1]};
               o_serial_out_pin <= tx_shift[1];
               if (tx_left == 4'h1) begin
                  tx_busy <= 1'b0;
                  o_serial_out_pin <= 1'b1;
               end
            end
         end
      end else begin
         o_serial_out_pin <= 1'b1;
      end
   end

endmodule // async_serial_port_one

// File: async_serial_port_one_chk.sv
// Port checker of the serial port
`timescale 1ns/100ps
module async_serial_port_one_chk (
   input wire i_clk,
   input wire i_rst,
   input wire [13:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [3:0] i_avs_byteenable,
   input wire [31:0] i_avs_writedata,
   input wire [31:0] o_avs_readdata,
   input wire o_avs_waitrequest,
   input wire i_timer_match,
   input wire i_serial_in_pin,
   input wire o_serial_out_pin,
   input wire o_tx_interrupt_port,
   input wire o_rx_interrupt_port
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // Pending request and a held line level
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_bit_hold;
      $stable(o_serial_out_pin) [*8];
   endsequence
   a_wait_one: assert property (s_req |=> !o_avs_waitrequest)
      else $error("waitrequest not low after request");
   a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_cause: assert property ($fell(o_avs_waitrequest) |-> $past(i_avs_read || i_avs_write))
      else $error("waitrequest low without request");
   a_rdata_upper: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h000000)
      else $error("readdata upper bits set");
   a_txirq_pulse: assert property (o_tx_interrupt_port |=> !o_tx_interrupt_port)
      else $error("tx interrupt longer than one cycle");
   a_rxirq_pulse: assert property (o_rx_interrupt_port |=> !o_rx_interrupt_port)
      else $error("rx interrupt longer than one cycle");
   a_start_low: assert property ($rose(o_tx_interrupt_port) |-> ##[0:1] !o_serial_out_pin)
      else $error("no start bit at frame start");
   a_bit_hold: assert property ($changed(o_serial_out_pin) |=> s_bit_hold)
      else $error("serial out bit too short");
endmodule // async_serial_port_one_chk

bind async_serial_port_one async_serial_port_one_chk chk (.i_clk(i_clk), .i_rst(i_rst),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_timer_match(i_timer_match), .i_serial_in_pin(i_serial_in_pin),
   .o_serial_out_pin(o_serial_out_pin), .o_tx_interrupt_port(o_tx_interrupt_port),
   .o_rx_interrupt_port(o_rx_interrupt_port));

// File: serial_port_consts.vh
// Register map, field positions, reset values and timing counts of the serial port
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH

// Register indexes; byte address is four times the index
`define IDX_STATUS_CTRL1 12'hF95
`define IDX_CTRL2 12'hF96
`define IDX_DATA 12'hF97

// Control one fields
`define C1_TX_EN 7
`define C1_RX_EN 6
`define C1_TX_STOP 5
`define C1_EVEN 4
`define C1_PAR_EN 3
`define C1_BAUD_HI 2
`define C1_BAUD_LO 0
`define C1_RESET 8'h00

// Control two fields
`define C2_FILT_HI 2
`define C2_FILT_LO 1
`define C2_RX_STOP 0
`define C2_RESET 3'h0

// Status fields
`define SR_PARITY_ERROR_FLAG 7
`define SR_FRAMING_ERROR_FLAG 6
`define SR_OVERRUN_FLAG 5
`define SR_RX_BUFFER_FULL_FLAG 4
`define SR_TX_DONE_FLAG 3
`define SR_TX_BUFFER_EMPTY_FLAG 2

// Baud select codes and main clock divisors of the sub-bit tick
`define BAUD_TIMER 3'h6
`define DIV_000 9'd13
`define DIV_001 9'd26
`define DIV_010 9'd52
`define DIV_011 9'd104
`define DIV_100 9'd208
`define DIV_101 9'd416
`define DIV_111 9'd96

// Sub-bit ticks per bit and sample positions
`define TICKS_LAST 4'hF
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_C 4'h9

// Noise filter: cycles a new level must persist before it passes
`define FILT_01 7'd31
`define FILT_10 7'd63
`define FILT_11 7'd127

`endif

// File: serial_remote_model.sv
// Remote transceiver: sends frames into the port and decodes its frames
`timescale 1ns/100ps
module serial_remote_model #(
   parameter BIT_CLKS = 208
) (
   input wire i_clk,
   input wire i_line,
   output reg o_line
);
   reg [7:0] got_byte;
   reg got_par;
   reg got_stop;
   reg [10:0] bits;
   integer frames;
   integer k;
   integer bit_clks;
   // Idle line is high; bit time may be changed between frames
   initial begin
      o_line = 1'b1;
      frames = 0;
      bit_clks = BIT_CLKS;
   end
   // Start, data LSB first, even parity, one stop of chosen level
   task send(input [7:0] b, input stop);
      integer j;
      begin
         for (j = 0; j < 11; j = j + 1) begin
            @(posedge i_clk);
            o_line <= (j == 0) ? 1'b0 : (j < 9) ? b[j-1] : (j == 9) ? ^b : stop;
            repeat (bit_clks - 1) @(posedge i_clk);
         end
         @(posedge i_clk);
         o_line <= 1'b1;
      end
   endtask
   // Short low pulse on an idle line
   task glitch(input integer n);
      begin
         @(posedge i_clk);
         o_line <= 1'b0;
         repeat (n) @(posedge i_clk);
         o_line <= 1'b1;
      end
   endtask
   // Decode frames from the port, sampling mid-bit
   initial begin
      forever begin
         @(negedge i_line);
         repeat (bit_clks / 2) @(posedge i_clk);
         for (k = 0; k < 11; k = k + 1) begin
            if (k > 0) repeat (bit_clks) @(posedge i_clk);
            bits[k] = i_line;
         end
         got_byte = bits[8:1];
         got_par = bits[9];
         got_stop = bits[10];
         frames = frames + 1;
      end
   end
endmodule // serial_remote_model

// File: tb_top.sv
// Self-checking bench of the serial port
`timescale 1ns/100ps
module tb_top;
   localparam [13:0] A_C1S = 14'h3E54;
   localparam [13:0] A_C2 = 14'h3E58;
   localparam [13:0] A_DAT = 14'h3E5C;
   reg i_clk = 1'b0;
   reg i_rst = 1'b1;
   reg [13:0] adr = 14'h0000;
   reg rd = 1'b0;
   reg wr = 1'b0;
   reg [31:0] wdat = 32'h00000000;
   reg [31:0] q;
   wire [31:0] rdat;
   wire wreq;
   wire s_out;
   wire s_in;
   wire tx_irq;
   wire rx_irq;
   integer err_count = 0;
   integer compares = 0;
   integer tx_irqs = 0;
   integer rx_irqs = 0;
   reg tmr = 1'b0;
   reg tmr_on = 1'b0;
   reg [3:0] tdiv = 4'h0;
   // Companion timer match every 13 clocks while enabled
   always @(posedge i_clk) begin
      tdiv <= (tdiv == 4'hC) ? 4'h0 : tdiv + 4'h1;
      tmr <= tmr_on & (tdiv == 4'h0);
   end
   async_serial_port_one uut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(4'hF),
      .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
      .i_timer_match(tmr), .i_serial_in_pin(s_in), .o_serial_out_pin(s_out),
      .o_tx_interrupt_port(tx_irq), .o_rx_interrupt_port(rx_irq));
   serial_remote_model #(.BIT_CLKS(208)) peer (.i_clk(i_clk), .i_line(s_out), .o_line(s_in));
   // Clock at 4 ns
   initial begin
      forever #2 i_clk = ~i_clk;
   end
   // Count interrupt pulses
   always @(posedge i_clk) begin
      if (tx_irq === 1'b1) tx_irqs <= tx_irqs + 1;
      if (rx_irq === 1'b1) rx_irqs <= rx_irqs + 1;
   end
   task summarize;
      begin
         $display("compares %0d errors %0d", compares, err_count);
         if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
         end else begin
            $display("[ FAIL ]");
         end
         $finish;
      end
   endtask
   task chk(input string name, input [31:0] exp, input [31:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   // Hold request until waitrequest is sampled low
   task bus(input r, input [13:0] a, input [7:0] d);
      begin
         @(posedge i_clk);
         rd <= r;
         wr <= !r;
         adr <= a;
         wdat <= {24'h000000, d};
         @(posedge i_clk);
         while (wreq !== 1'b0) @(posedge i_clk);
         q = rdat;
         rd <= 1'b0;
         wr <= 1'b0;
      end
   endtask
   task t_reset;
      begin
         bus(1, A_C1S, 0);
         chk("status", 32'h0C, q);
         bus(1, 14'h0000, 0);
         chk("unmapped", 32'h0, q);
         bus(1, A_DAT, 0);
         chk("rx buf", 32'h0, q);
         bus(0, A_C1S, 8'hD8);
         bus(0, A_C2, 8'h00);
      end
   endtask
   // A write while disabled uses up the status read; the next write is refused
   task t_nostat;
      begin
         bus(0, A_C1S, 8'h58);
         bus(0, A_DAT, 8'h11);
         bus(0, A_C1S, 8'hD8);
         bus(0, A_DAT, 8'h22);
         repeat (300) @(posedge i_clk);
         chk("tx irqs", 0, tx_irqs);
         chk("line", 1, s_out);
         bus(1, A_C1S, 0);
         chk("status", 32'h0C, q);
      end
   endtask
   task t_tx;
      integer n;
      begin
         n = 0;
         bus(0, A_DAT, 8'hA5);
         bus(1, A_C1S, 0);
         chk("status busy", 32'h04, q);
         chk("tx irqs", 1, tx_irqs);
         while (peer.frames != 1 && n < 3000) begin
            @(posedge i_clk);
            n = n + 1;
         end
         chk("tx byte", 8'hA5, peer.got_byte);
         chk("tx parity", 0, peer.got_par);
         chk("tx stop", 1, peer.got_stop);
         repeat (250) @(posedge i_clk);
         bus(1, A_C1S, 0);
         chk("status done", 32'h0C, q);
      end
   endtask
   task t_rx;
      begin
         peer.send(8'h3C, 1'b1);
         repeat (100) @(posedge i_clk);
         chk("rx irqs", 1, rx_irqs);
         bus(1, A_C1S, 0);
         chk("status full", 32'h1C, q);
         bus(1, A_DAT, 0);
         chk("rx byte", 32'h3C, q);
         bus(1, A_C1S, 0);
         chk("status clr", 32'h0C, q);
      end
   endtask
   task t_ovr;
      begin
         peer.send(8'h01, 1'b1);
         peer.send(8'h02, 1'b1);
         repeat (100) @(posedge i_clk);
         bus(1, A_C1S, 0);
         chk("status ovr", 32'h3C, q);
         bus(1, A_DAT, 0);
         chk("kept byte", 32'h01, q);
         bus(1, A_C1S, 0);
         chk("ovr clr", 32'h0C, q);
      end
   endtask
   task t_framing_error_flag;
      begin
         peer.send(8'h5A, 1'b0);
         repeat (300) @(posedge i_clk);
         bus(1, A_C1S, 0);
         chk("framing", 32'h40, q & 32'h40);
         bus(1, A_DAT, 0);
         bus(1, A_C1S, 0);
         chk("framing clr", 32'h00, q & 32'h40);
      end
   endtask
   // Receive disable, input filter and two receive stops
   task t_rx_opts;
      integer n0;
      begin
         n0 = rx_irqs;
         bus(0, A_C1S, 8'h98);
         peer.send(8'h3C, 1'b1);
         repeat (100) @(posedge i_clk);
         chk("rx off", n0, rx_irqs);
         bus(0, A_C2, 8'h03);
         bus(0, A_C1S, 8'hD8);
         peer.glitch(20);
         repeat (300) @(posedge i_clk);
         chk("glitch", n0, rx_irqs);
         peer.send(8'hC3, 1'b1);
         repeat (100) @(posedge i_clk);
         chk("one stop early", n0, rx_irqs);
         repeat (300) @(posedge i_clk);
         chk("two stops", n0 + 1, rx_irqs);
         bus(1, A_C1S, 0);
         bus(1, A_DAT, 0);
         chk("filtered byte", 32'hC3, q);
         bus(0, A_C2, 8'h00);
      end
   endtask
   // Timer-paced transmit with two stops and odd parity
   task t_timer;
      begin
         tmr_on <= 1'b1;
         bus(0, A_C1S, 8'hEE);
         bus(1, A_C1S, 0);
         bus(0, A_DAT, 8'h3C);
         wait (peer.frames == 2);
         chk("timer byte", 8'h3C, peer.got_byte);
         chk("odd parity", 1, peer.got_par);
         repeat (150) @(posedge i_clk);
         bus(1, A_C1S, 0);
         chk("second stop", 32'h04, q);
         repeat (300) @(posedge i_clk);
         bus(1, A_C1S, 0);
         chk("timer done", 32'h0C, q);
         tmr_on <= 1'b0;
      end
   endtask
   // Divide-by-96 code against a matching far-side bit time
   task t_rate;
      begin
         peer.bit_clks = 1536;
         bus(0, A_C1S, 8'hDF);
         bus(1, A_C1S, 0);
         bus(0, A_DAT, 8'h81);
         wait (peer.frames == 3);
         chk("rate byte", 8'h81, peer.got_byte);
         chk("rate parity", 0, peer.got_par);
      end
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      t_reset;
      t_nostat;
      t_tx;
      t_rx;
      t_ovr;
      t_framing_error_flag;
      t_rx_opts;
      t_timer;
      t_rate;
      summarize;
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge i_clk);
      err_count = err_count + 1;
      summarize;
   end
endmodule // tb_top
